/* File: rtl/rst_seq_cfg.svh */
// Constants of the reset and brown-out sequencer
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

`define RSQ_ADDR_W 8
`define RSQ_DATA_W 8
`define RSQ_CTRL_OFFSET 8'h00
`define RSQ_STAT_OFFSET 8'h01
`define RSQ_CTRL_SWEN_BIT 7
`define RSQ_CTRL_FAST_BIT 6
`define RSQ_CTRL_RESET 8'h80
`define RSQ_STAT_READY_BIT 0
`define RSQ_STAT_BOREV_BIT 1
`define RSQ_STAT_POREV_BIT 2
`define RSQ_SYNC_W 5
`define RSQ_SYNC_RESET 5'h07

`define RSQ_CLK_PERIOD_NS 25
`define RSQ_POWER_UP_DELAY_TIMER_TIME_MS 64
`define RSQ_POWER_UP_DELAY_TIMER_CYCLES ((`RSQ_POWER_UP_DELAY_TIMER_TIME_MS * 1000000) / `RSQ_CLK_PERIOD_NS)
`define RSQ_FILTER_TIME_NS 1000
`define RSQ_FILTER_CYCLES \
  ((`RSQ_FILTER_TIME_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)

`endif

/* File: rtl/rst_seq_pkg.sv */
// Types of the reset and brown-out sequencer
package rst_seq_pkg;

  typedef enum logic [1:0] {
    BO_OFF = 2'h0,
    BO_SW = 2'h1,
    BO_NOSLEEP = 2'h2,
    BO_ON = 2'h3
  } brownout_mode_t;

  typedef enum logic [5:0] {
    ST_HOLD = 6'h01,
    ST_BORWAIT = 6'h02,
    ST_POWER_UP_DELAY_TIMER = 6'h04,
    ST_OST = 6'h08,
    ST_EXTERNAL_RESET_PIN = 6'h10,
    ST_RUN = 6'h20
  } seq_state_t;

  typedef struct packed {
    brownout_mode_t brownout_mode_select;
    logic brownout_level_select;
    logic power_up_delay_disable_n;
    logic external_reset_enable;
    logic osc_startup_required;
  } cfg_word_t;

  typedef struct packed {
    logic watchdog;
    logic reset_instr;
    logic stack_overflow;
    logic stack_underflow;
    logic programming_exit;
  } reset_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

endpackage

/* File: rtl/reset_powerup_brownout_sequencer.sv */
// Power-up, brown-out and reset source sequencer with register port
`include "rst_seq_cfg.svh"

// Behaviour
// - hold core while power-on detector active
// - delay timer gives nominal 64 ms
// - core held while delay timer runs
// - delay timer only when disable_n is zero
// - timer starts after power-on and brown-out release
// - four monitor modes from two-bit field
// - one bit selects trip threshold
// - only dips longer than filter trip
// - mode 11 always on, start waits ready
// - mode 11 active in sleep, no wake delay
// - mode 10 off asleep, start waits ready
// - mode 10 wake waits for ready
// - mode 01 software enable, no start wait
// - mode 01 protects once ready, status readable
// - mode 01 state ignores sleep
// - disabled monitor lets execution start immediately
// - forced-on monitor ready before execution
// - eight reset sources enter reset
// - order: delay timer, oscillator, pin release
// - software enable always read/write, used in 01
module reset_powerup_brownout_sequencer #(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `RSQ_POWER_UP_DELAY_TIMER_CYCLES,
  parameter int unsigned FILTER_CYCLES = `RSQ_FILTER_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic por_active,
  input wire logic supply_below_high,
  input wire logic supply_below_low,
  input wire logic brownout_circuit_ready,
  input wire logic external_reset_pin_n,
  input wire logic sleep_mode,
  input wire logic osc_startup_done,
  input wire rst_seq_pkg::cfg_word_t cfg,
  input wire rst_seq_pkg::reset_src_t reset_src,
  input wire rst_seq_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  output logic core_reset,
  output logic exec_release,
  output logic wake_permit,
  output logic brownout_monitor_on,
  output logic bandgap_force_on,
  output logic brownout_reset_event
);
  import rst_seq_pkg::*;

  localparam int unsigned PW_W = $clog2(POWER_UP_DELAY_TIMER_CYCLES + 1);
  localparam int unsigned FL_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [PW_W-1:0] POWER_UP_DELAY_TIMER_LAST = PW_W'(POWER_UP_DELAY_TIMER_CYCLES - 1);
  localparam logic [FL_W-1:0] FILT_LIM = FL_W'(FILTER_CYCLES);
  localparam logic [`RSQ_SYNC_W-1:0] SYNC_RST = `RSQ_SYNC_RESET;

  logic [`RSQ_SYNC_W-1:0] async_in;
  logic [`RSQ_SYNC_W-1:0] sync1_reg;
  logic [`RSQ_SYNC_W-1:0] sync2_reg;
  logic por_s;
  logic below_hi_s;
  logic below_lo_s;
  logic ready_s;
  logic pin_n_s;
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [PW_W-1:0] power_up_delay_timer_cnt_reg;
  logic [FL_W-1:0] filt_cnt_reg;
  logic bor_hold_reg;
  logic [7:0] ctrl_reg;
  logic por_flag_reg;
  logic bor_flag_reg;
  logic [7:0] rdata_reg;
  logic below_sel;
  logic monitor_active;
  logic protect;
  logic bor_trip;
  logic start_wait;
  logic cold_reset;
  logic warm_reset;
  logic stat_clr_bor;
  logic stat_clr_por;
  brownout_mode_t mode;

  assign async_in = {external_reset_pin_n, brownout_circuit_ready, supply_below_low,
                     supply_below_high, por_active};

  // Two-stage synchronisers for analog and pin inputs
  genvar gi;
  generate
    for (gi = 0; gi < `RSQ_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
        end else if (clk_en) begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign por_s = sync2_reg[0];
  assign below_hi_s = sync2_reg[1];
  assign below_lo_s = sync2_reg[2];
  assign ready_s = sync2_reg[3];
  assign pin_n_s = sync2_reg[4];
  assign mode = cfg.brownout_mode_select;

  assign below_sel = cfg.brownout_level_select ? below_hi_s : below_lo_s;

  always_comb begin
    unique case (mode)
      BO_ON: monitor_active = 1'b1;
      BO_NOSLEEP: monitor_active = ~sleep_mode;
      BO_SW: monitor_active = ctrl_reg[`RSQ_CTRL_SWEN_BIT];
      BO_OFF: monitor_active = 1'b0;
    endcase
  end

  assign protect = monitor_active & ready_s;

  assign bor_trip = protect & below_sel & (filt_cnt_reg == FILT_LIM);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_cnt_reg <= '0;
    end else if (clk_en) begin
      if (!(protect && below_sel)) begin
        filt_cnt_reg <= '0;
      end else if (filt_cnt_reg != FILT_LIM) begin
        filt_cnt_reg <= filt_cnt_reg + FL_W'(1);
      end
    end
  end

  // Brown-out hold lasts until supply recovers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bor_hold_reg <= 1'b0;
    end else if (clk_en) begin
      if (bor_trip) begin
        bor_hold_reg <= 1'b1;
      end else if (!below_sel) begin
        bor_hold_reg <= 1'b0;
      end
    end
  end

  assign cold_reset = por_s | reset_src.programming_exit | bor_trip;
  assign warm_reset = (cfg.external_reset_enable & ~pin_n_s) | reset_src.watchdog |
                      reset_src.reset_instr | reset_src.stack_overflow |
                      reset_src.stack_underflow;

  assign start_wait = (mode == BO_ON) || (mode == BO_NOSLEEP);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HOLD: begin
        if (!por_s && !bor_hold_reg) begin
          state_next = ST_BORWAIT;
        end
      end
      ST_BORWAIT: begin
        if (!start_wait || (ready_s && !below_sel)) begin
          state_next = cfg.power_up_delay_disable_n ? ST_OST : ST_POWER_UP_DELAY_TIMER;
        end
      end
      ST_POWER_UP_DELAY_TIMER: begin
        if (power_up_delay_timer_cnt_reg == POWER_UP_DELAY_TIMER_LAST) begin
          state_next = ST_OST;
        end
      end
      ST_OST: begin
        if (!cfg.osc_startup_required || osc_startup_done) begin
          state_next = ST_EXTERNAL_RESET_PIN;
        end
      end
      ST_EXTERNAL_RESET_PIN: begin
        if (!cfg.external_reset_enable || pin_n_s) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (warm_reset) begin
          state_next = ST_EXTERNAL_RESET_PIN;
        end
      end
      default: state_next = ST_HOLD;
    endcase
    if (cold_reset || bor_hold_reg) begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_HOLD;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_up_delay_timer_cnt_reg <= '0;
    end else if (clk_en) begin
      if (state_reg != ST_POWER_UP_DELAY_TIMER) begin
        power_up_delay_timer_cnt_reg <= '0;
      end else if (power_up_delay_timer_cnt_reg != POWER_UP_DELAY_TIMER_LAST) begin
        power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + PW_W'(1);
      end
    end
  end

  assign core_reset = (state_reg != ST_RUN);
  assign exec_release = (state_reg == ST_RUN);
  assign wake_permit = !((mode == BO_NOSLEEP) && !ready_s);
  assign brownout_monitor_on = monitor_active;
  assign bandgap_force_on = ctrl_reg[`RSQ_CTRL_FAST_BIT] &
                            ((mode == BO_NOSLEEP) || (mode == BO_SW));
  assign brownout_reset_event = bor_trip;

  assign stat_clr_bor = bus.wr && (bus.addr == `RSQ_STAT_OFFSET) &&
                        bus.wdata[`RSQ_STAT_BOREV_BIT];
  assign stat_clr_por = bus.wr && (bus.addr == `RSQ_STAT_OFFSET) &&
                        bus.wdata[`RSQ_STAT_POREV_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `RSQ_CTRL_RESET;
    end else if (clk_en && bus.wr && (bus.addr == `RSQ_CTRL_OFFSET)) begin
      ctrl_reg <= {bus.wdata[7:6], 6'h00};
    end
  end

  // Sticky event flags, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bor_flag_reg <= 1'b0;
      por_flag_reg <= 1'b1;
    end else if (clk_en) begin
      bor_flag_reg <= bor_trip | (bor_flag_reg & ~stat_clr_bor);
      por_flag_reg <= por_s | (por_flag_reg & ~stat_clr_por);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= 8'h00;
      if (bus.rd && (bus.addr == `RSQ_CTRL_OFFSET)) begin
        rdata_reg <= ctrl_reg;
      end else if (bus.rd && (bus.addr == `RSQ_STAT_OFFSET)) begin
        rdata_reg <= {5'h00, por_flag_reg, bor_flag_reg, protect};
      end
    end
  end

  assign rdata = rdata_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_por_hold;
    clk_en && por_s |=> core_reset && state_reg == ST_HOLD;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("core left reset under power-on");

  property p_power_up_delay_timer_hold;
    state_reg == ST_POWER_UP_DELAY_TIMER |-> core_reset && !exec_release;
  endproperty
  a_power_up_delay_timer_hold: assert property (p_power_up_delay_timer_hold) else $error("core released in delay");

  property p_power_up_delay_timer_en;
    state_reg == ST_POWER_UP_DELAY_TIMER |-> !cfg.power_up_delay_disable_n;
  endproperty
  a_power_up_delay_timer_en: assert property (p_power_up_delay_timer_en) else $error("delay ran while disabled");

  property p_power_up_delay_timer_start;
    $rose(state_reg == ST_POWER_UP_DELAY_TIMER) |-> $past(state_reg) == ST_BORWAIT && !$past(por_s);
  endproperty
  a_power_up_delay_timer_start: assert property (p_power_up_delay_timer_start) else $error("delay began early");

  property p_power_up_delay_timer_len;
    clk_en && state_reg == ST_POWER_UP_DELAY_TIMER && power_up_delay_timer_cnt_reg != POWER_UP_DELAY_TIMER_LAST && !cold_reset &&
      !bor_hold_reg |=> state_reg == ST_POWER_UP_DELAY_TIMER;
  endproperty
  a_power_up_delay_timer_len: assert property (p_power_up_delay_timer_len) else $error("delay ended early");

  property p_filter;
    clk_en && protect && below_sel && filt_cnt_reg == '0 |=> !bor_trip;
  endproperty
  a_filter: assert property (p_filter) else $error("short dip tripped");

  property p_mode_off_start;
    clk_en && state_reg == ST_BORWAIT && !start_wait && !cold_reset && !bor_hold_reg
      |=> state_reg != ST_BORWAIT;
  endproperty
  a_mode_off_start: assert property (p_mode_off_start) else $error("start waited");

  property p_on_wait;
    clk_en && state_reg == ST_BORWAIT && mode == BO_ON && !ready_s |=> !exec_release[*2];
  endproperty
  a_on_wait: assert property (p_on_wait) else $error("start ran before ready");

  property p_order;
    $rose(exec_release) |-> $past(state_reg) == ST_EXTERNAL_RESET_PIN;
  endproperty
  a_order: assert property (p_order) else $error("release out of order");

  property p_wake;
    mode == BO_ON |-> wake_permit;
  endproperty
  a_wake: assert property (p_wake) else $error("mode 11 delayed wake");

  property p_wake10;
    mode == BO_NOSLEEP && !ready_s |-> !wake_permit;
  endproperty
  a_wake10: assert property (p_wake10) else $error("mode 10 woke unready");

  property p_trip_reset;
    clk_en && bor_trip |=> core_reset && state_reg == ST_HOLD;
  endproperty
  a_trip_reset: assert property (p_trip_reset) else $error("trip left core running");

  property p_sw_start;
    clk_en && state_reg == ST_BORWAIT && mode == BO_SW && !cold_reset && !bor_hold_reg
      |=> state_reg != ST_BORWAIT;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software mode start waited");

  property p_ready_stat;
    clk_en && bus.rd && bus.addr == `RSQ_STAT_OFFSET |=>
      rdata[`RSQ_STAT_READY_BIT] == $past(protect);
  endproperty
  a_ready_stat: assert property (p_ready_stat) else $error("ready status wrong");

  property p_freeze;
    !clk_en |=> $stable(state_reg) && $stable(power_up_delay_timer_cnt_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  c_run: cover property (state_reg == ST_OST ##1 state_reg == ST_EXTERNAL_RESET_PIN ##1 exec_release);
  c_trip: cover property (bor_trip);
  c_power_up_delay_timer: cover property ($fell(state_reg == ST_POWER_UP_DELAY_TIMER));
  c_warm: cover property (exec_release && warm_reset ##1 core_reset);

endmodule // reset_powerup_brownout_sequencer

/* File: bench/supply_model.sv */
// Behavioural supply detectors, reset pin and oscillator timer
module supply_model #(
  parameter int READY_DLY = 12
) (
  input wire logic clk,
  input wire logic por_req,
  input wire logic [1:0] level,
  input wire logic pin_low,
  input wire logic monitor_on,
  output logic por_active,
  output logic supply_below_high,
  output logic supply_below_low,
  output logic brownout_circuit_ready,
  output logic external_reset_pin_n,
  output logic osc_startup_done
);
  int rdy_cnt;
  int osc_cnt;

  assign por_active = por_req;
  assign supply_below_high = (level != 2'h0);
  assign supply_below_low = (level == 2'h2);

  always_ff @(posedge clk) begin
    if (!monitor_on) begin
      rdy_cnt <= 0;
    end else if (rdy_cnt < READY_DLY) begin
      rdy_cnt <= rdy_cnt + 1;
    end
  end
  assign brownout_circuit_ready = monitor_on && (rdy_cnt == READY_DLY);

  // Weak pull-up on the reset pin
  assign external_reset_pin_n = !pin_low;

  always_ff @(posedge clk) begin
    if (por_req) begin
      osc_cnt <= 0;
    end else if (osc_cnt < 4) begin
      osc_cnt <= osc_cnt + 1;
    end
  end
  assign osc_startup_done = (osc_cnt == 4);
endmodule // supply_model

/* File: bench/reset_powerup_brownout_sequencer_tb_top.sv */
// Self-checking bench for the reset and brown-out sequencer
module reset_powerup_brownout_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rst_seq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic sleep_mode = 1'b0;
  logic por_req = 1'b1;
  logic [1:0] level = 2'h0;
  logic pin_low = 1'b0;
  cfg_word_t cfg = '0;
  reset_src_t reset_src = '0;
  bus_req_t bus = '0;
  logic [7:0] rdata, d;
  logic core_reset, exec_release, wake_permit, mon_on, bg_on, bo_event, saw;
  logic por_a, below_hi, below_lo, bo_rdy, pin_n, osc_done;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;

  always #12.5 clk = ~clk;

  supply_model #(.READY_DLY(12)) partner (.clk(clk), .por_req(por_req), .level(level),
    .pin_low(pin_low), .monitor_on(mon_on), .por_active(por_a), .supply_below_high(below_hi),
    .supply_below_low(below_lo), .brownout_circuit_ready(bo_rdy),
    .external_reset_pin_n(pin_n), .osc_startup_done(osc_done));

  reset_powerup_brownout_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(20), .FILTER_CYCLES(4)) dut (.clk(clk),
    .rst(rst), .clk_en(clk_en), .por_active(por_a), .supply_below_high(below_hi),
    .supply_below_low(below_lo), .brownout_circuit_ready(bo_rdy),
    .external_reset_pin_n(pin_n), .sleep_mode(sleep_mode), .osc_startup_done(osc_done),
    .cfg(cfg), .reset_src(reset_src), .bus(bus), .rdata(rdata), .core_reset(core_reset),
    .exec_release(exec_release), .wake_permit(wake_permit), .brownout_monitor_on(mon_on),
    .bandgap_force_on(bg_on), .brownout_reset_event(bo_event));

  task end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task flag(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    v = rdata;
  endtask

  task wait_rel(input int lim);
    n = 0;
    while (exec_release !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  task boot(input brownout_mode_t m, input logic dn, input logic sel, input int lim);
    @(posedge clk);
    rst <= 1'b1;
    por_req <= 1'b1;
    cfg <= '{brownout_mode_select: m, brownout_level_select: sel,
      power_up_delay_disable_n: dn, external_reset_enable: 1'b1, osc_startup_required: 1'b1};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    flag(core_reset, 1'b1);
    por_req <= 1'b0;
    wait_rel(lim);
  endtask

  initial begin
    // Monitor off, supply low, no delay
    level <= 2'h2;
    boot(BO_OFF, 1'b1, 1'b0, 40);
    flag(n < 12, 1'b1);
    rd(8'h00, d);
    check(d, 8'h80);
    rd(8'h01, d);
    check(d, 8'h04);
    wr(8'h01, 8'h04);
    rd(8'h01, d);
    check(d, 8'h00);
    rd(8'h05, d);
    check(d, 8'h00);
    wr(8'h00, 8'h40);
    rd(8'h00, d);
    check(d, 8'h40);
    flag(bg_on, 1'b0);
    // Delay timer enabled
    level <= 2'h0;
    boot(BO_OFF, 1'b0, 1'b0, 100);
    flag(n >= 20 && n < 32, 1'b1);
    // Always-on waits for ready and supply
    level <= 2'h2;
    boot(BO_ON, 1'b1, 1'b0, 40);
    flag(exec_release, 1'b0);
    level <= 2'h0;
    wait_rel(20);
    flag(n < 20, 1'b1);
    rd(8'h01, d);
    flag(d[0], 1'b1);
    sleep_mode <= 1'b1;
    repeat (8) @(posedge clk);
    flag(wake_permit, 1'b1);
    flag(mon_on, 1'b1);
    sleep_mode <= 1'b0;
    // Low threshold ignores a below-high supply
    level <= 2'h1;
    repeat (12) @(posedge clk);
    flag(exec_release, 1'b1);
    level <= 2'h2;
    repeat (2) @(posedge clk);
    level <= 2'h0;
    repeat (8) @(posedge clk);
    flag(exec_release, 1'b1);
    level <= 2'h2;
    saw = 1'b0;
    repeat (12) begin
      @(posedge clk);
      saw |= bo_event;
    end
    flag(saw, 1'b1);
    flag(core_reset, 1'b1);
    level <= 2'h0;
    wait_rel(40);
    rd(8'h01, d);
    flag(d[1], 1'b1);
    // High threshold selected
    boot(BO_ON, 1'b1, 1'b1, 40);
    level <= 2'h1;
    repeat (12) @(posedge clk);
    flag(core_reset, 1'b1);
    level <= 2'h0;
    // Off in sleep
    boot(BO_NOSLEEP, 1'b1, 1'b0, 40);
    flag(n < 40, 1'b1);
    sleep_mode <= 1'b1;
    repeat (8) @(posedge clk);
    flag(mon_on, 1'b0);
    flag(wake_permit, 1'b0);
    sleep_mode <= 1'b0;
    repeat (20) @(posedge clk);
    flag(wake_permit, 1'b1);
    // Software mode starts without waiting
    level <= 2'h2;
    sleep_mode <= 1'b1;
    boot(BO_SW, 1'b1, 1'b0, 40);
    flag(n < 12, 1'b1);
    saw = 1'b0;
    repeat (30) begin
      @(posedge clk);
      saw |= bo_event;
    end
    flag(saw, 1'b1);
    level <= 2'h0;
    wait_rel(40);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    flag(mon_on, 1'b1);
    sleep_mode <= 1'b0;
    wr(8'h00, 8'h40);
    @(posedge clk);
    flag(mon_on, 1'b0);
    flag(bg_on, 1'b1);
    // Each remaining reset source
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      reset_src <= reset_src_t'(5'h10 >> i);
      @(posedge clk);
      reset_src <= '0;
      saw = 1'b0;
      repeat (4) begin
        @(posedge clk);
        saw |= core_reset;
      end
      flag(saw, 1'b1);
      wait_rel(40);
    end
    pin_low <= 1'b1;
    repeat (6) @(posedge clk);
    flag(core_reset, 1'b1);
    pin_low <= 1'b0;
    wait_rel(20);
    flag(n < 20, 1'b1);
    // Writes are ignored while the clock enable is low
    clk_en <= 1'b0;
    wr(8'h00, 8'h80);
    clk_en <= 1'b1;
    rd(8'h00, d);
    check(d, 8'h40);
    end_sim();
  end

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule // reset_powerup_brownout_sequencer_tb_top
